// *** adc_cfg_regs_cfg.svh ***
/*
  Offsets, reset values, masks, field positions and codes of the setup
  and filter configuration register slice.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ADC_CFG_REGS_CFG_SVH
`define ADC_CFG_REGS_CFG_SVH

// Register addresses
`define ADR_SETUP1      8'h21
`define ADR_SETUP2      8'h22
`define ADR_SETUP3      8'h23
`define ADR_FILT0       8'h28

// Reset values and writable masks
`define SETUP_RST       16'h1320
`define SETUP_WMASK     16'h1fb0
`define FILT_RST        16'h0507
`define FILT_WMASK      16'h8f7f
`define FILT_MAP_WMASK  16'hffff

// Setup field positions
`define SU_POL          12
`define SU_REFBUF_P     11
`define SU_REFBUF_N     10
`define SU_INBUF_P      9
`define SU_INBUF_N      8
`define SU_OPEN_WIRE    7
`define SU_REF_HI       5
`define SU_REF_LO       4

// Filter field positions
`define FI_MAP          15
`define FI_DEC_HI       14
`define FI_POST_EN      11
`define FI_PSEL_HI      10
`define FI_PSEL_LO      8
`define FI_RANK_HI      6
`define FI_RANK_LO      5
`define FI_RATE_HI      4

// Codes
`define REF_EXTERNAL    2'h0
`define REF_INTERNAL    2'h2
`define REF_SUPPLY      2'h3
`define RANK_SINC5_1    2'h0
`define RANK_SINC3      2'h3
`define PSEL_27         3'h2
`define PSEL_25         3'h3
`define PSEL_20         3'h5
`define PSEL_16_67      3'h6

// Direct decimation scale: left shift giving modulator clocks per output per unit (32)
`define MAP_DIV_SHIFT   5

`endif

// *** adc_cfg_regs_pkg.sv ***
/*
  Types of the setup and filter configuration register slice.
  Assumes nothing of its surroundings.
*/
package adc_cfg_regs_pkg;

  // Decoded per-setup configuration
  typedef struct packed {
    logic       code_polarity_select;
    logic       pos_reference_buffer_enable;
    logic       neg_reference_buffer_enable;
    logic       pos_input_buffer_enable;
    logic       neg_input_buffer_enable;
    logic       open_wire_current_enable;
    logic [1:0] reference_source_select;
  } setup_cfg_t;

  // Decoded filter configuration
  typedef struct packed {
    logic        direct_decimation_map;
    logic [14:0] decimation_value;
    logic        mains_postfilter_enable;
    logic [2:0]  mains_postfilter_select;
    logic [1:0]  filter_rank_select;
    logic [4:0]  output_rate_code;
  } filter_cfg_t;

endpackage : adc_cfg_regs_pkg

// *** adc_setup_filter_config_regs.sv ***
/*
  Setup configuration registers 1 to 3 and filter configuration
  register 0, with decoded outputs and a conversion restart pulse.
  Assumes a serial interface front end that presents one 16-bit word
  access per strobe, synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_regs_cfg.svh"

// Functional notes
// - A filter register write pulses restart, aborting conversion to first channel.
// - The filter register is 16 bits holding rate and filter options.
// - Bit 15 set turns bits 14:0 into a sinc3 decimation value.
// - Mapped rate is modulator clock over 32 times bits 14:0.
// - Postfilter only acts with filter order 00; software picks that first.
// - Postfilter select bits 10:8, codes 010,011,101,110; reset 0x5.
// - Filter order bits 6:5: 00 sinc5 plus sinc1 default, 11 sinc3.
// - Output rate bits 4:0 set rate for the setup; reset 0x07.
// - Filter register 0 at 0x28, reset 0x0507.
// - Setup registers 1 to 3 at 0x21 to 0x23, reset 0x1320, read-write.
// - Setup registers 1 to 3 share setup 0 bit layout.
// - Reference select 00 external, 10 internal, 11 supply; internal needs mode enable.
// - Each input buffer bit switches its buffer on at 1, off at 0.
module adc_setup_filter_config_regs (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  // Register access
  input  wire logic [7:0]                     reg_addr,
  input  wire logic                           reg_wr_en,
  input  wire logic                           reg_rd_en,
  input  wire logic [15:0]                    reg_wdata,
  output var  logic [15:0]                    reg_rdata_q,
  output var  logic                           reg_rd_valid_q,
  output var  logic                           reg_addr_err_q,
  // Mode register state
  input  wire logic                           int_ref_on,
  // Decoded configuration
  output var  adc_cfg_regs_pkg::setup_cfg_t [2:0] setup_cfg_q,
  output var  adc_cfg_regs_pkg::filter_cfg_t  filter_cfg_q,
  output var  logic [19:0]                    decim_divisor_q,
  // Status and events
  output var  logic                           restart_q,
  output var  logic                           reserved_code_q,
  output var  logic                           ref_missing_q
);

  logic [15:0]                      setup_reg_q [3];
  logic [15:0]                      setup_reg_d [3];
  logic [15:0]                      filt_reg_q;
  logic [15:0]                      filt_reg_d;
  logic [15:0]                      reg_rdata_d;
  logic                             reg_rd_valid_d;
  logic                             reg_addr_err_d;
  adc_cfg_regs_pkg::setup_cfg_t [2:0] setup_cfg_d;
  adc_cfg_regs_pkg::filter_cfg_t    filter_cfg_d;
  logic [19:0]                      decim_divisor_d;
  logic                             restart_d;
  logic                             reserved_code_d;
  logic                             ref_missing_d;
  logic                             filt_hit;

  // Setup word to fields, shared by all three setups
  function automatic adc_cfg_regs_pkg::setup_cfg_t setup_decode(
    input logic [15:0] w
  );
    adc_cfg_regs_pkg::setup_cfg_t s;
    s.code_polarity_select        = w[`SU_POL];
    s.pos_reference_buffer_enable = w[`SU_REFBUF_P];
    s.neg_reference_buffer_enable = w[`SU_REFBUF_N];
    s.pos_input_buffer_enable     = w[`SU_INBUF_P];
    s.neg_input_buffer_enable     = w[`SU_INBUF_N];
    s.open_wire_current_enable    = w[`SU_OPEN_WIRE];
    s.reference_source_select     = w[`SU_REF_HI:`SU_REF_LO];
    return s;
  endfunction : setup_decode

  // Modulator clocks per output in direct decimation mode
  function automatic logic [19:0] map_divisor(input logic [14:0] n);
    return {n, {`MAP_DIV_SHIFT{1'b0}}};
  endfunction : map_divisor

  assign filt_hit = reg_wr_en && (reg_addr == `ADR_FILT0);

  // Register writes
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      setup_reg_d[i] = setup_reg_q[i];
      if (reg_wr_en && (reg_addr == `ADR_SETUP1 + 8'(i))) begin
        setup_reg_d[i] = reg_wdata & `SETUP_WMASK;
      end
    end
    filt_reg_d = filt_reg_q;
    if (filt_hit) begin
      // Mapped mode keeps all of bits 14:0 as the decimation value
      if (reg_wdata[`FI_MAP]) begin
        filt_reg_d = reg_wdata & `FILT_MAP_WMASK;
      end else begin
        filt_reg_d = reg_wdata & `FILT_WMASK;
      end
    end
  end

  // Decode of next register contents
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      setup_cfg_d[i] = setup_decode(setup_reg_d[i]);
    end
    filter_cfg_d.direct_decimation_map = filt_reg_d[`FI_MAP];
    filter_cfg_d.decimation_value      = filt_reg_d[`FI_DEC_HI:0];
    filter_cfg_d.mains_postfilter_select =
      filt_reg_d[`FI_PSEL_HI:`FI_PSEL_LO];
    filter_cfg_d.filter_rank_select =
      filt_reg_d[`FI_RANK_HI:`FI_RANK_LO];
    filter_cfg_d.output_rate_code = filt_reg_d[`FI_RATE_HI:0];
    // Postfilter gated by sinc5 plus sinc1 and no direct mapping
    filter_cfg_d.mains_postfilter_enable = filt_reg_d[`FI_POST_EN] &&
      !filt_reg_d[`FI_MAP] &&
      (filt_reg_d[`FI_RANK_HI:`FI_RANK_LO] == `RANK_SINC5_1);
    if (filt_reg_d[`FI_MAP]) begin
      decim_divisor_d = map_divisor(filt_reg_d[`FI_DEC_HI:0]);
    end else begin
      decim_divisor_d = 20'h00000;
    end
    reserved_code_d = 1'b0;
    if (!filt_reg_d[`FI_MAP]) begin
      case (filt_reg_d[`FI_RANK_HI:`FI_RANK_LO])
        `RANK_SINC5_1, `RANK_SINC3: ;
        default: reserved_code_d = 1'b1;
      endcase
      if (filt_reg_d[`FI_POST_EN]) begin
        case (filt_reg_d[`FI_PSEL_HI:`FI_PSEL_LO])
          `PSEL_27, `PSEL_25, `PSEL_20, `PSEL_16_67: ;
          default: reserved_code_d = 1'b1;
        endcase
      end
    end
    ref_missing_d = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (setup_cfg_d[i].reference_source_select == `REF_INTERNAL &&
          !int_ref_on) begin
        ref_missing_d = 1'b1;
      end
    end
    restart_d = filt_hit;
  end

  // Read path
  always_comb begin
    reg_rdata_d    = 16'h0000;
    reg_rd_valid_d = reg_rd_en;
    reg_addr_err_d = 1'b0;
    if (reg_rd_en) begin
      case (reg_addr)
        `ADR_SETUP1: reg_rdata_d = setup_reg_q[0];
        `ADR_SETUP2: reg_rdata_d = setup_reg_q[1];
        `ADR_SETUP3: reg_rdata_d = setup_reg_q[2];
        `ADR_FILT0:  reg_rdata_d = filt_reg_q;
        default:     reg_addr_err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        setup_reg_q[i] <= `SETUP_RST;
        setup_cfg_q[i] <= setup_decode(`SETUP_RST);
      end
      filt_reg_q      <= `FILT_RST;
      filter_cfg_q    <= '0;
      filter_cfg_q.mains_postfilter_select <= 3'h5;
      filter_cfg_q.output_rate_code <= 5'h07;
      filter_cfg_q.decimation_value <= 15'(`FILT_RST);
      decim_divisor_q <= 20'h00000;
      reg_rdata_q     <= 16'h0000;
      reg_rd_valid_q  <= 1'b0;
      reg_addr_err_q  <= 1'b0;
      restart_q       <= 1'b0;
      reserved_code_q <= 1'b0;
      ref_missing_q   <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        setup_reg_q[i] <= setup_reg_d[i];
        setup_cfg_q[i] <= setup_cfg_d[i];
      end
      filt_reg_q      <= filt_reg_d;
      filter_cfg_q    <= filter_cfg_d;
      decim_divisor_q <= decim_divisor_d;
      reg_rdata_q     <= reg_rdata_d;
      reg_rd_valid_q  <= reg_rd_valid_d;
      reg_addr_err_q  <= reg_addr_err_d;
      restart_q       <= restart_d;
      reserved_code_q <= reserved_code_d;
      ref_missing_q   <= ref_missing_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  restart_pulse_a: assert property (
    filt_hit |=> restart_q ##1 (!restart_q || $past(filt_hit)))
    else $error("restart not a pulse after filter write");

  restart_cause_a: assert property (
    restart_q |-> $past(reg_wr_en) && $past(reg_addr) == `ADR_FILT0)
    else $error("restart without filter write");

  rate_store_a: assert property (
    filt_hit && !reg_wdata[15] |=>
      filter_cfg_q.output_rate_code == $past(reg_wdata[4:0]) &&
      filter_cfg_q.filter_rank_select == $past(reg_wdata[6:5]))
    else $error("rate or order field not stored");

  map_store_a: assert property (
    filt_hit && reg_wdata[15] |=> filter_cfg_q.direct_decimation_map &&
      filter_cfg_q.decimation_value == $past(reg_wdata[14:0]))
    else $error("direct decimation value not stored");

  map_divisor_a: assert property (
    filter_cfg_q.direct_decimation_map |->
      decim_divisor_q == 20'(filter_cfg_q.decimation_value) * 20'h00020)
    else $error("mapped divisor not 32 times value");

  post_gate_a: assert property (
    filter_cfg_q.mains_postfilter_enable |->
      filter_cfg_q.filter_rank_select == 2'h0 &&
      !filter_cfg_q.direct_decimation_map)
    else $error("postfilter active outside sinc5 plus sinc1");

  resv_zero_a: assert property (
    reg_rd_en && reg_addr == `ADR_FILT0 |=> reg_rd_valid_q &&
      (reg_rdata_q[15] || (reg_rdata_q[14:12] == 3'h0 && !reg_rdata_q[7])))
    else $error("reserved filter bits read nonzero");

  setup_wr_a: assert property (
    reg_wr_en && reg_addr == `ADR_SETUP2 |=>
      setup_cfg_q[1] == setup_decode($past(reg_wdata)))
    else $error("setup 2 write not reflected");

  inbuf_a: assert property (
    reg_wr_en && reg_addr == `ADR_SETUP1 |=>
      setup_cfg_q[0].pos_input_buffer_enable == $past(reg_wdata[9]) &&
      setup_cfg_q[0].neg_input_buffer_enable == $past(reg_wdata[8]))
    else $error("input buffer enables not reflected");

  filt_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    rst ##1 !rst |-> filt_reg_q == `FILT_RST && !restart_q)
    else $error("filter register reset value wrong");

  setup_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> setup_cfg_q[2] == setup_decode(`SETUP_RST))
    else $error("setup register reset value wrong");

  unmapped_a: assert property (
    reg_rd_en && reg_addr == 8'h24 |=> reg_addr_err_q && reg_rdata_q == 0)
    else $error("unmapped read not flagged");

  post_sel_a: assert property (
    filt_hit && !reg_wdata[15] |=>
      filter_cfg_q.mains_postfilter_select == $past(reg_wdata[10:8]))
    else $error("postfilter select not stored");

  rank_flag_a: assert property (
    filt_hit && !reg_wdata[15] && reg_wdata[6:5] == 2'h1 |=>
      reserved_code_q)
    else $error("reserved filter order not flagged");

  map_quiet_a: assert property (
    filter_cfg_q.direct_decimation_map |->
      !reserved_code_q && !filter_cfg_q.mains_postfilter_enable)
    else $error("filter options active in direct mapping");

  divisor_zero_a: assert property (
    !filter_cfg_q.direct_decimation_map |-> decim_divisor_q == 20'h00000)
    else $error("divisor set outside direct mapping");

  ref_present_a: assert property (
    int_ref_on |=> !ref_missing_q)
    else $error("reference flag with internal reference on");

  rd_pulse_a: assert property (
    reg_rd_en |=> reg_rd_valid_q ##1 (reg_rd_valid_q == $past(reg_rd_en)))
    else $error("read valid not a one-cycle pulse");

  open_wire_a: assert property (
    reg_wr_en && reg_addr == `ADR_SETUP3 |=>
      setup_cfg_q[2].open_wire_current_enable == $past(reg_wdata[7]))
    else $error("open wire enable not reflected");

  map_cov_c: cover property (filt_hit && reg_wdata[15] ##1 restart_q);
  post_cov_c: cover property (filter_cfg_q.mains_postfilter_enable);
  resv_cov_c: cover property (reserved_code_q);
  ref_cov_c: cover property (ref_missing_q);

endmodule : adc_setup_filter_config_regs

`default_nettype wire

// *** host_model.sv ***
/*
  Host controller model: word reads and writes on the register port.
  Assumes wr and rd are called from one process of the testbench.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_regs_cfg.svh"
module host_model (
  // Clock
  input  wire logic        clk,
  // Register access
  output var  logic [7:0]  reg_addr,
  output var  logic        reg_wr_en,
  output var  logic        reg_rd_en,
  output var  logic [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata_q,
  input  wire logic        reg_rd_valid_q,
  input  wire logic        reg_addr_err_q
);
  logic [15:0] rdata;
  logic        rvalid;
  logic        rerr;
  initial begin
    reg_addr  = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 16'h0000;
  end
  // Reserved filter bits cleared unless raw asked for
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic raw);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = (raw || a != `ADR_FILT0 || d[15]) ? d : d & 16'h8f7f;
    reg_wr_en = 1'b1;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(posedge clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    rdata     = reg_rdata_q;
    rvalid    = reg_rd_valid_q;
    rerr      = reg_addr_err_q;
  endtask : rd
endmodule : host_model
`default_nettype wire

// *** tb.sv ***
/*
  Self-checking testbench of the setup and filter register slice.
  Assumes the host model drives all register accesses.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                              clk;
  logic                              rst;
  logic                              int_ref_on;
  logic [7:0]                        reg_addr;
  logic                              reg_wr_en;
  logic                              reg_rd_en;
  logic [15:0]                       reg_wdata;
  logic [15:0]                       reg_rdata_q;
  logic                              reg_rd_valid_q;
  logic                              reg_addr_err_q;
  adc_cfg_regs_pkg::setup_cfg_t [2:0] setup_cfg_q;
  adc_cfg_regs_pkg::filter_cfg_t     filter_cfg_q;
  logic [19:0]                       decim_divisor_q;
  logic                              restart_q;
  logic                              reserved_code_q;
  logic                              ref_missing_q;
  int                                fail_count = 0;
  int                                comparisons = 0;
  logic [2:0]                        sel_codes [6] = '{2, 3, 5, 6, 7, 0};

  adc_setup_filter_config_regs adc_setup_filter_config_regs_inst (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_rd_valid_q(reg_rd_valid_q),
    .reg_addr_err_q(reg_addr_err_q), .int_ref_on(int_ref_on),
    .setup_cfg_q(setup_cfg_q), .filter_cfg_q(filter_cfg_q),
    .decim_divisor_q(decim_divisor_q), .restart_q(restart_q),
    .reserved_code_q(reserved_code_q), .ref_missing_q(ref_missing_q));

  host_model host_model_inst (
    .clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_rd_valid_q(reg_rd_valid_q),
    .reg_addr_err_q(reg_addr_err_q));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] su(input logic [15:0] v);
    return {v[12:7], v[5:4]};
  endfunction : su

  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    host_model_inst.rd(a);
    chk(host_model_inst.rvalid, 1'b1);
    chk(host_model_inst.rdata, exp);
  endtask : rdchk

  task automatic t_reset;
    for (int i = 0; i < 3; i++) begin
      rdchk(8'h21 + 8'(i), 16'h1320);
      chk(setup_cfg_q[i], su(16'h1320));
    end
    rdchk(8'h28, 16'h0507);
    chk(filter_cfg_q.mains_postfilter_select, 3'h5);
    chk(filter_cfg_q.output_rate_code, 5'h07);
    chk(filter_cfg_q.filter_rank_select, 2'h0);
    host_model_inst.rd(8'h24);
    chk({host_model_inst.rerr, host_model_inst.rdata}, 17'h10000);
  endtask : t_reset

  task automatic t_setup;
    logic [15:0] w [3] = '{16'hffcf, 16'h02a0, 16'h0130};
    logic [15:0] e [3] = '{16'h1f80, 16'h02a0, 16'h0130};
    for (int i = 0; i < 3; i++) begin
      host_model_inst.wr(8'h21 + 8'(i), w[i], 1'b1);
      chk(setup_cfg_q[i], su(e[i]));
      rdchk(8'h21 + 8'(i), e[i]);
    end
    chk(ref_missing_q, 1'b1);
    int_ref_on = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(ref_missing_q, 1'b0);
  endtask : t_setup

  task automatic t_filter;
    host_model_inst.wr(8'h28, 16'h0a0c, 1'b0);
    chk(restart_q, 1'b1);
    chk(filter_cfg_q.mains_postfilter_enable, 1'b1);
    chk(filter_cfg_q.output_rate_code, 5'h0c);
    @(posedge clk);
    #1;
    chk(restart_q, 1'b0);
    foreach (sel_codes[i]) begin
      host_model_inst.wr(8'h28, {5'h01, sel_codes[i], 8'h0c}, 1'b0);
      @(posedge clk);
      #1;
      chk(filter_cfg_q.mains_postfilter_select, sel_codes[i]);
      chk(reserved_code_q, sel_codes[i] inside {7, 0});
    end
    host_model_inst.wr(8'h28, 16'h0e6c, 1'b0);
    @(posedge clk);
    #1;
    chk(filter_cfg_q.mains_postfilter_enable, 1'b0);
    chk(filter_cfg_q.filter_rank_select, 2'h3);
    chk(reserved_code_q, 1'b0);
    host_model_inst.wr(8'h28, 16'h0520, 1'b0);
    @(posedge clk);
    #1;
    chk(reserved_code_q, 1'b1);
    host_model_inst.wr(8'h28, 16'h7fff, 1'b1);
    rdchk(8'h28, 16'h0f7f);
    host_model_inst.wr(8'h29, 16'h0000, 1'b0);
    chk(restart_q, 1'b0);
  endtask : t_filter

  task automatic t_map;
    logic [15:0] v [2] = '{16'h9234, 16'hffff};
    foreach (v[i]) begin
      host_model_inst.wr(8'h28, v[i], 1'b0);
      chk(restart_q, 1'b1);
      @(posedge clk);
      #1;
      chk(filter_cfg_q.direct_decimation_map, 1'b1);
      chk(filter_cfg_q.decimation_value, v[i][14:0]);
      chk(decim_divisor_q, {v[i][14:0], 5'h00});
      rdchk(8'h28, v[i]);
    end
  endtask : t_map

  task automatic print_verdict;
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end

  initial begin
    rst        = 1'b1;
    int_ref_on = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_setup();
    t_filter();
    t_map();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
